// ===== serial_port_consts.vh
`ifndef SERIAL_PORT_CONSTS_VH
`define SERIAL_PORT_CONSTS_VH

// register word offsets (byte addresses)
`define SP_OFS_CONTROL      8'h00
`define SP_OFS_PEND_CLEAR   8'h04
`define SP_OFS_BIT_RATE     8'h08
`define SP_OFS_DATA         8'h0c
`define SP_OFS_KEY_STATUS   8'h10

// control register fields
`define SP_CTL_MODULE_EN    0
`define SP_CTL_NINE_BIT     1
`define SP_CTL_RX_IRQ_EN    2
`define SP_CTL_TX_IRQ_EN    3
`define SP_CTL_TWO_STOP     4
`define SP_CTL_CLK_SRC      5
`define SP_CTL_SINGLE_WIRE  6
`define SP_CTL_RX_EN        7
`define SP_CTL_TX_DONE      8
`define SP_CTL_RX_DONE      9

// pending-clear fields
`define SP_CLR_TX_DONE      8
`define SP_CLR_RX_DONE      9
`define SP_CLR_KEY          16
`define SP_CLR_RESET_KEY    17

// reset values
`define SP_CONTROL_RESET    8'h00
`define SP_DIVISOR_RESET    16'h0000

`endif

// ===== async_serial_port_zero.v
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

`include "serial_port_consts.vh"

// Summary of operation
// - rx done set on complete character
// - tx done set when character shifted out
// - receiver runs only when enabled
// - single wire mode shares one line
// - control bit 5 picks divisor clock
// - control bit 4 selects two stop bits
// - tx done raises irq when enabled
// - rx done raises irq when enabled
// - nine bit mode uses data bit 8
// - control bit 0 enables transmitter, receiver and data loads; key match flags run regardless
// - write one clears rx done flag
// - tx done cleared by clear or write
// - write one clears key match flags
// - rx rate is source over divisor+1
// - tx rate is source over divisor+1
// - data write loads transmit buffer
// - data read returns receive buffer
module async_serial_port_zero #(
    parameter DIV_W = 16
) (
    // clock and reset
    input  wire        clk,
    input  wire        srst,
    // register port
    input  wire [7:0]  addr,
    input  wire [31:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [31:0] rdata,
    // alternate increment clock, a pin
    input  wire        inc_clk_in,
    // key match events from outside logic
    input  wire        key_match_evt,
    input  wire        reset_key_match_evt,
    // serial lines
    output reg         tx_out,
    output reg         tx_oe,
    input  wire        rx_in,
    // interrupt request
    output reg         irq
);

    // transmitter states
    localparam TX_IDLE  = 2'd0;
    localparam TX_START = 2'd1;
    localparam TX_DATA  = 2'd2;
    localparam TX_STOP  = 2'd3;
    // receiver states
    localparam RX_IDLE  = 2'd0;
    localparam RX_START = 2'd1;
    localparam RX_DATA  = 2'd2;
    localparam RX_STOP  = 2'd3;

    // control and data registers
    reg [7:0]       control_r;
    reg             tx_done_flag_r;
    reg             rx_done_flag_r;
    reg             key_flag_r;
    reg             reset_key_flag_r;
    reg [DIV_W-1:0] rx_divisor_r;
    reg [DIV_W-1:0] tx_divisor_r;
    reg [8:0]       transmit_buffer_r;
    reg             tx_pend_r;
    reg [8:0]       rx_buffer_r;

    // pin synchronisers
    reg [1:0]       rx_sync_r;
    reg [1:0]       inc_sync_r;
    reg             inc_prev_r;

    // transmitter
    reg [1:0]       tx_state_r;
    reg [DIV_W-1:0] tx_cnt_r;
    reg [8:0]       tx_shift_r;
    reg [3:0]       tx_bits_r;

    // receiver
    reg [1:0]       rx_state_r;
    reg [DIV_W-1:0] rx_cnt_r;
    reg [8:0]       rx_shift_r;
    reg [3:0]       rx_bits_r;

    // control fields and register decodes
    wire module_en   = control_r[`SP_CTL_MODULE_EN];
    wire nine_bit    = control_r[`SP_CTL_NINE_BIT];
    wire two_stop    = control_r[`SP_CTL_TWO_STOP];
    wire single_wire = control_r[`SP_CTL_SINGLE_WIRE];
    wire rx_enable   = control_r[`SP_CTL_RX_EN];
    wire wr_ctl      = wr && (addr == `SP_OFS_CONTROL);
    wire wr_clr      = wr && (addr == `SP_OFS_PEND_CLEAR);
    wire wr_rate     = wr && (addr == `SP_OFS_BIT_RATE);
    wire wr_data     = wr && (addr == `SP_OFS_DATA);
    // data bits per frame
    wire [3:0] nbits = nine_bit ? 4'h9 : 4'h8;

    // divisor count reached: one bit time elapsed
    function div_end;
        input [DIV_W-1:0] cnt;
        input [DIV_W-1:0] div;
        begin
            div_end = (cnt == div);
        end
    endfunction

    // next value of a bit-time counter
    function [DIV_W-1:0] cnt_inc;
        input [DIV_W-1:0] cnt;
        begin
            cnt_inc = cnt + {{(DIV_W-1){1'b0}}, 1'b1};
        end
    endfunction

    // pins come from outside the clock domain, two stages each
    always @(posedge clk) begin
        if (srst) begin
            rx_sync_r  <= 2'h3;
            inc_sync_r <= 2'h0;
            inc_prev_r <= 1'b0;
        end else begin
            rx_sync_r  <= {rx_sync_r[0], rx_in};
            inc_sync_r <= {inc_sync_r[0], inc_clk_in};
            inc_prev_r <= inc_sync_r[1];
        end
    end

    // divisor tick: every system cycle or each rising edge of the increment clock
    wire inc_rise  = inc_sync_r[1] & ~inc_prev_r;
    wire src_tick  = control_r[`SP_CTL_CLK_SRC] ? inc_rise : 1'b1;
    // in single wire mode the receiver listens to the shared line, which the
    // transmitter drives while busy; no frame starts while it drives, so its own frames are not heard
    wire line_in   = single_wire ? (tx_oe ? tx_out : rx_sync_r[1]) : rx_sync_r[1];

    // the last stop bit has run its full bit time
    wire tx_fin = (tx_state_r == TX_STOP) && src_tick && div_end(tx_cnt_r, tx_divisor_r)
                  && (tx_bits_r == 4'h0);
    // stop bit seen high at mid bit; a low one drops the frame
    wire rx_fin = (rx_state_r == RX_STOP) && src_tick && div_end(rx_cnt_r, rx_divisor_r)
                  && line_in;
    // write-one clears, and the data load that also clears tx done
    wire tx_clr_req   = wr_clr && wdata[`SP_CLR_TX_DONE];
    wire rx_clr_req   = wr_clr && wdata[`SP_CLR_RX_DONE];
    wire key_clr_req  = wr_clr && wdata[`SP_CLR_KEY];
    wire rkey_clr_req = wr_clr && wdata[`SP_CLR_RESET_KEY];
    wire data_load    = wr_data && module_en;

    // control byte and divisors; the divisors cannot be read back
    always @(posedge clk) begin
        if (srst) begin
            control_r    <= `SP_CONTROL_RESET;
            rx_divisor_r <= `SP_DIVISOR_RESET;
            tx_divisor_r <= `SP_DIVISOR_RESET;
        end else begin
            if (wr_ctl)
                control_r <= wdata[7:0];
            if (wr_rate) begin
                rx_divisor_r <= wdata[31:16];
                tx_divisor_r <= wdata[15:0];
            end
        end
    end

    // one character waits; a write before the transmitter takes it
    // replaces it, since there is no deeper buffer
    always @(posedge clk) begin
        if (srst) begin
            transmit_buffer_r <= 9'h000;
            tx_pend_r         <= 1'b0;
        end else if (!module_en) begin
            tx_pend_r <= 1'b0;
        end else if (data_load) begin
            transmit_buffer_r <= wdata[8:0];
            tx_pend_r         <= 1'b1;
        end else if (tx_state_r == TX_IDLE) begin
            tx_pend_r <= 1'b0;
        end
    end

    // transmit done; the hardware set wins over a clear in one cycle
    always @(posedge clk) begin
        if (srst)
            tx_done_flag_r <= 1'b0;
        else if (tx_fin)
            tx_done_flag_r <= 1'b1;
        else if (tx_clr_req || data_load)
            tx_done_flag_r <= 1'b0;
    end

    // receive done; a frame ending at the clear is not lost
    always @(posedge clk) begin
        if (srst)
            rx_done_flag_r <= 1'b0;
        else if (rx_fin)
            rx_done_flag_r <= 1'b1;
        else if (rx_clr_req)
            rx_done_flag_r <= 1'b0;
    end

    // key match flags; event and clear together leave the flag set
    always @(posedge clk) begin
        if (srst) begin
            key_flag_r       <= 1'b0;
            reset_key_flag_r <= 1'b0;
        end else begin
            if (key_match_evt)
                key_flag_r <= 1'b1;
            else if (key_clr_req)
                key_flag_r <= 1'b0;
            if (reset_key_match_evt)
                reset_key_flag_r <= 1'b1;
            else if (rkey_clr_req)
                reset_key_flag_r <= 1'b0;
        end
    end

    // transmitter: start low, data lsb first, one or two high stop bits
    always @(posedge clk) begin
        if (srst || !module_en) begin
            tx_state_r <= TX_IDLE;
            tx_cnt_r   <= {DIV_W{1'b0}};
            tx_shift_r <= 9'h000;
            tx_bits_r  <= 4'h0;
            tx_out     <= 1'b1;
            tx_oe      <= 1'b0;
        end else begin
            case (tx_state_r)
                // idle: hold the line high and wait for a character
                TX_IDLE: begin
                    tx_out <= 1'b1;
                    tx_oe  <= ~single_wire;
                    tx_cnt_r <= {DIV_W{1'b0}};
                    if (tx_pend_r) begin
                        tx_shift_r <= transmit_buffer_r;
                        tx_state_r <= TX_START;
                        tx_out     <= 1'b0;
                        tx_oe      <= 1'b1;
                    end
                end
                // every bit lasts divisor+1 ticks of the chosen source
                TX_START, TX_DATA, TX_STOP: begin
                    if (src_tick) begin
                        if (div_end(tx_cnt_r, tx_divisor_r)) begin
                            tx_cnt_r <= {DIV_W{1'b0}};
                            // start bit done: first data bit out
                            if (tx_state_r == TX_START) begin
                                tx_out     <= tx_shift_r[0];
                                tx_shift_r <= {1'b0, tx_shift_r[8:1]};
                                tx_bits_r  <= nbits - 4'h1;
                                tx_state_r <= TX_DATA;
                            end else if (tx_state_r == TX_DATA) begin
                                // last data bit done: stop bits follow
                                if (tx_bits_r == 4'h0) begin
                                    tx_out     <= 1'b1;
                                    tx_bits_r  <= two_stop ? 4'h1 : 4'h0;
                                    tx_state_r <= TX_STOP;
                                end else begin
                                    tx_out     <= tx_shift_r[0];
                                    tx_shift_r <= {1'b0, tx_shift_r[8:1]};
                                    tx_bits_r  <= tx_bits_r - 4'h1;
                                end
                            end else if (tx_bits_r != 4'h0) begin
                                tx_bits_r <= tx_bits_r - 4'h1;
                            end else begin
                                tx_state_r <= TX_IDLE;
                                tx_oe      <= ~single_wire;
                            end
                        end else begin
                            tx_cnt_r <= cnt_inc(tx_cnt_r);
                        end
                    end
                end
                default: tx_state_r <= TX_IDLE;
            endcase
        end
    end

    // receiver: start found on a falling line, bits sampled at mid bit
    wire [DIV_W-1:0] rx_half = {1'b0, rx_divisor_r[DIV_W-1:1]};
    always @(posedge clk) begin
        if (srst || !module_en || !rx_enable) begin
            rx_state_r <= RX_IDLE;
            rx_cnt_r   <= {DIV_W{1'b0}};
            rx_shift_r <= 9'h000;
            rx_bits_r  <= 4'h0;
        end else begin
            case (rx_state_r)
                RX_IDLE: begin
                    rx_cnt_r <= {DIV_W{1'b0}};
                    if (!line_in && !(single_wire && tx_oe))
                        rx_state_r <= RX_START;
                end
                // confirm the start bit half a bit time later
                RX_START: begin
                    if (src_tick) begin
                        if (div_end(rx_cnt_r, rx_half)) begin
                            rx_cnt_r <= {DIV_W{1'b0}};
                            rx_bits_r <= nbits;
                            rx_state_r <= line_in ? RX_IDLE : RX_DATA; // glitch rejected
                        end else begin
                            rx_cnt_r <= cnt_inc(rx_cnt_r);
                        end
                    end
                end
                RX_DATA, RX_STOP: begin
                    if (src_tick) begin
                        if (div_end(rx_cnt_r, rx_divisor_r)) begin
                            rx_cnt_r <= {DIV_W{1'b0}};
                            if (rx_state_r == RX_DATA) begin
                                // lsb first: shift down from the top of the word
                                rx_shift_r <= nine_bit ? {line_in, rx_shift_r[8:1]}
                                                       : {1'b0, line_in, rx_shift_r[7:1]};
                                rx_bits_r  <= rx_bits_r - 4'h1;
                                if (rx_bits_r == 4'h1)
                                    rx_state_r <= RX_STOP;
                            end else begin
                                // one stop bit is checked; a second is left to idle
                                rx_state_r <= RX_IDLE;
                            end
                        end else begin
                            rx_cnt_r <= cnt_inc(rx_cnt_r);
                        end
                    end
                end
                default: rx_state_r <= RX_IDLE;
            endcase
        end
    end

    // receive buffer updated only on a good frame
    always @(posedge clk) begin
        if (srst)
            rx_buffer_r <= 9'h000;
        else if (rx_fin)
            rx_buffer_r <= rx_shift_r;
    end

    // read data one cycle after the read strobe; unmapped reads zero
    always @(posedge clk) begin
        if (srst) begin
            rdata <= 32'h0000_0000;
        end else if (rd) begin
            case (addr)
                // done flags sit just above the control byte
                `SP_OFS_CONTROL:    rdata <= {22'h0, rx_done_flag_r, tx_done_flag_r, control_r};
                `SP_OFS_DATA:       rdata <= {23'h0, rx_buffer_r};
                `SP_OFS_KEY_STATUS: rdata <= {30'h0, reset_key_flag_r, key_flag_r};
                default:            rdata <= 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

    // interrupt request from enabled done flags
    always @(posedge clk) begin
        if (srst)
            irq <= 1'b0;
        else
            irq <= (tx_done_flag_r & control_r[`SP_CTL_TX_IRQ_EN])
                 | (rx_done_flag_r & control_r[`SP_CTL_RX_IRQ_EN]);
    end

endmodule

`default_nettype wire

// ===== async_serial_port_zero_properties.sv
`timescale 1ns/1ps
`default_nettype none
module serial_port_checker (
    // clock and reset
    input wire logic        clk,
    input wire logic        srst,
    // register port
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    // events, lines and request
    input wire logic        key_match_evt,
    input wire logic        tx_out,
    input wire logic        tx_oe,
    input wire logic        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // multi-step accesses: write then read-back, event then status read
    sequence ctl_wr_rd;
        wr && addr == 8'h00 ##1 rd && addr == 8'h00;
    endsequence
    sequence key_set_rd;
        key_match_evt ##1 rd && addr == 8'h10;
    endsequence
    sequence key_clr_rd;
        wr && addr == 8'h04 && wdata[16] && !key_match_evt ##1 rd && addr == 8'h10 && !key_match_evt;
    endsequence
    rd_idle_zero_a: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data not zero outside a read");
    ctl_upper_a: assert property ($past(rd) && $past(addr) == 8'h00 |-> rdata[31:10] == 22'h0)
        else $error("control read has upper bits set");
    data_upper_a: assert property ($past(rd) && $past(addr) == 8'h0c |-> rdata[31:9] == 23'h0)
        else $error("data read has upper bits set");
    wo_read_a: assert property ($past(rd) && ($past(addr) inside {8'h04, 8'h08}) |-> rdata == 32'h0)
        else $error("write-only register read back nonzero");
    ctl_readback_a: assert property (ctl_wr_rd |=> rdata[7:0] == $past(wdata[7:0], 2))
        else $error("control bits not read back as written");
    irq_mask_a: assert property (wr && addr == 8'h00 && wdata[3:2] == 2'b00 |-> ##2 !irq)
        else $error("request raised with both enables off");
    disable_idle_a: assert property (wr && addr == 8'h00 && !wdata[0] |-> ##2 (!tx_oe && tx_out))
        else $error("transmit pin active after module disable");
    idle_high_a: assert property (!tx_oe |-> tx_out)
        else $error("transmit line low while not driven");
    key_set_a: assert property (key_set_rd |=> rdata[0])
        else $error("key event not seen in status");
    key_clear_a: assert property (key_clr_rd |=> !rdata[0])
        else $error("key flag survived its clear");
endmodule
bind async_serial_port_zero serial_port_checker u_serial_port_checker (
    .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .key_match_evt(key_match_evt), .tx_out(tx_out), .tx_oe(tx_oe), .irq(irq));
`default_nettype wire

// ===== serial_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
// serial peer: idles high, sends and takes whole frames at a given bit time
module serial_peer_model (
    // clock for bit timing
    input  wire logic clk,
    // serial lines
    input  wire logic line_in,
    output var logic  line_out
);
    initial line_out = 1'b1;
    // start low, data lsb first, then stop bits high
    task automatic send(input logic [8:0] d, input int nb, input int bc, input int ns);
        line_out <= 1'b0;
        repeat (bc) @(posedge clk);
        for (int i = 0; i < nb + ns; i++) begin
            line_out <= (i < nb) ? d[i] : 1'b1;
            repeat (bc) @(posedge clk);
        end
    endtask
    // bounded wait for a start edge, then sample each bit near its middle
    task automatic take(output logic [8:0] d, output logic ok, input int nb, input int bc);
        int n;
        n = 0;
        d = 9'h0;
        while (line_in && n < 2000) begin
            @(posedge clk);
            n++;
        end
        repeat (bc / 2) @(posedge clk);
        for (int i = 0; i < nb; i++) begin
            repeat (bc) @(posedge clk);
            d[i] = line_in;
        end
        repeat (bc) @(posedge clk);
        ok = line_in && n < 2000;
    endtask
endmodule
`default_nettype wire

// ===== async_serial_port_zero_bench.sv
`timescale 1ns/1ps
`default_nettype none
module async_serial_port_zero_bench;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        key_match_evt = 1'b0;
    logic        reset_key_match_evt = 1'b0;
    logic [1:0]  inc_div_r = 2'h0;
    logic        shared_mode = 1'b0;
    wire  [31:0] rdata;
    wire         tx_out;
    wire         tx_oe;
    wire         irq;
    wire         peer_out;
    // undriven pin is pulled high; shared mode wires both parties together
    wire         pin_line = tx_oe ? tx_out : 1'b1;
    wire         rx_in = shared_mode ? (pin_line & peer_out) : peer_out;
    int          num_errors = 0;
    int          checks_done = 0;
    int          n;
    int          n2;
    int          n3;
    logic [31:0] v;
    logic [8:0]  got;
    logic        ok;
    // rows: address, write value, expected read-back
    logic [71:0] rows [7] = '{{8'h08, 32'h0007_0003, 32'h0}, {8'h00, 32'hffff_ffff, 32'hff},
        {8'h00, 32'h0, 32'h0}, {8'h04, 32'hffff_ffff, 32'h0}, {8'h10, 32'hffff_ffff, 32'h0},
        {8'h14, 32'hffff_ffff, 32'h0}, {8'h0c, 32'h1ff, 32'h0}};
    initial forever #2.5 clk = ~clk;
    // alternate increment clock, one rising edge every four system cycles
    always @(posedge clk) inc_div_r <= inc_div_r + 2'h1;
    async_serial_port_zero u_async_serial_port_zero (.clk(clk), .srst(srst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .inc_clk_in(inc_div_r[1]),
        .key_match_evt(key_match_evt), .reset_key_match_evt(reset_key_match_evt),
        .tx_out(tx_out), .tx_oe(tx_oe), .rx_in(rx_in), .irq(irq));
    serial_peer_model u_serial_peer_model (.clk(clk), .line_in(pin_line), .line_out(peer_out));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
            num_errors++;
        end
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rreg(input logic [7:0] a, output logic [31:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
        @(posedge clk);
    endtask
    // bounded wait on the request line; a hang ends the run
    task automatic wait_irq(output int c);
        c = 0;
        while (irq !== 1'b1 && c < 400) begin
            @(posedge clk);
            c++;
        end
        if (c == 400) begin
            num_errors++;
            test_done();
        end
    endtask
    task automatic tx_frame(input logic [31:0] d, input int nb, input int bc);
        fork
            u_serial_peer_model.take(got, ok, nb, bc);
            wreg(8'h0c, d);
        join
        chk({22'h0, ok, got}, {22'h0, 1'b1, d[8:0]});
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        rreg(a, v);
        chk(v, e);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk({29'h0, tx_out, tx_oe, irq}, 32'h4);
        for (int i = 0; i < 7; i++) begin
            wreg(rows[i][71:64], rows[i][63:32]);
            rd_chk(rows[i][71:64], rows[i][31:0]);
        end
        // eight bits, one stop, tx divisor 3 against rx divisor 7
        wreg(8'h00, 32'h8d);
        tx_frame(32'ha5, 8, 4);
        wait_irq(n2);
        rd_chk(8'h00, 32'h18d);
        // nine bits, two stops: a new character clears the done flag
        wreg(8'h00, 32'h9f);
        fork
            u_serial_peer_model.take(got, ok, 9, 4);
            begin
                wreg(8'h0c, 32'h15a);
                rd_chk(8'h00, 32'h9f);
            end
        join
        chk({22'h0, ok, got}, 32'h35a);
        wait_irq(n3);
        chk(32'(n3 - n2), 32'h4);
        wreg(8'h04, 32'h100);
        rd_chk(8'h00, 32'h9f);
        // nine-bit receive; a zero clear leaves the flag alone
        u_serial_peer_model.send(9'h1c3, 9, 8, 2);
        wait_irq(n);
        rd_chk(8'h0c, 32'h1c3);
        wreg(8'h04, 32'h0);
        rd_chk(8'h00, 32'h29f);
        wreg(8'h04, 32'h200);
        rd_chk(8'h00, 32'h9f);
        // receiver off, then on with its request masked
        wreg(8'h00, 32'h09);
        u_serial_peer_model.send(9'h055, 8, 8, 1);
        rd_chk(8'h00, 32'h09);
        wreg(8'h00, 32'h89);
        u_serial_peer_model.send(9'h0aa, 8, 8, 1);
        rd_chk(8'h00, 32'h289);
        chk({31'h0, irq}, 32'h0);
        wreg(8'h00, 32'h8d);
        wait_irq(n);
        rd_chk(8'h0c, 32'haa);
        wreg(8'h04, 32'h200);
        // divisor fed by the alternate clock: 4 ticks of 4 cycles per bit
        wreg(8'h00, 32'had);
        tx_frame(32'h96, 8, 16);
        wait_irq(n);
        wreg(8'h04, 32'h100);
        // single wire: pin released when idle, own frame not received
        shared_mode <= 1'b1;
        wreg(8'h00, 32'hc9);
        u_serial_peer_model.send(9'h05a, 8, 8, 1);
        chk({31'h0, tx_oe}, 32'h0);
        rd_chk(8'h0c, 32'h5a);
        wreg(8'h04, 32'h200);
        tx_frame(32'h0f, 8, 4);
        repeat (8) @(posedge clk);
        rd_chk(8'h00, 32'h1c9);
        // key match flags and their write-one clears
        key_match_evt <= 1'b1;
        reset_key_match_evt <= 1'b1;
        @(posedge clk);
        key_match_evt <= 1'b0;
        reset_key_match_evt <= 1'b0;
        rd_chk(8'h10, 32'h3);
        wreg(8'h04, 32'h10000);
        rd_chk(8'h10, 32'h2);
        wreg(8'h04, 32'h20000);
        rd_chk(8'h10, 32'h0);
        test_done();
    end
endmodule
`default_nettype wire
